/* File: logic/dcdc_ctrl.sv */
// APB register block and PWM timing for the dc-dc converter
//
// Summary of operation
// RULE_01: Transistor three current reads as an 8-bit code, 37.6 uA a step.
// RULE_02: Transistor four current reads the same way as transistor three.
// RULE_03: Transistor five current reads as an 8-bit code, 0.316 mA a step.
// RULE_04: Transistor six current reads the same way as transistor five.
// RULE_05: The PWM period is the 8-bit period code times 61.035 ns.
// RULE_06: Period bit 6 always reads one and ignores writes.
// RULE_07: Writing one to the calibration bit starts it; it reads one meanwhile.
// RULE_08: A read-only bit tells if feed-forward follows or inverts the drive.
// RULE_09: Each PWM cycle keeps the switch off at least (off code + 4) steps.
// RULE_10: Drive pulse width is (pulse code - off code - 4) steps; the code uses the period code in place of a pulse code above it.
// RULE_11: Writes to the four current sense registers are ignored.
// RULE_12: The calibration bit clears itself when calibration finishes.
`timescale 1ns/1ps
module dcdc_ctrl #(
   parameter int ADDR_W = 12,
   parameter int CAL_CYCLES = dcdc_ctrl_pkg::CAL_CYCLES_DEFAULT,
   parameter bit FF_SAME_POLARITY = 1'b0
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Current monitor measurements
   input wire logic [7:0] ext_transistor_three,
   input wire logic [7:0] ext_transistor_four,
   input wire logic [7:0] ext_transistor_five,
   input wire logic [7:0] ext_transistor_six,
   // Converter pins and calibration state
   output logic converter_drive_pin,
   output logic feedforward_pin,
   output logic peak_monitor_cal
);

   if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_chk
      $error("ADDR_W must lie in 10..32");
   end
   if (CAL_CYCLES < 2 || CAL_CYCLES > 65535) begin : g_cal_chk
      $error("CAL_CYCLES must lie in 2..65535");
   end

   // Sense codes
   logic [7:0] xtor3_current_code;
   logic [7:0] xtor4_current_code;
   logic [7:0] xtor5_current_code;
   logic [7:0] xtor6_current_code;
   // Control registers
   logic [7:0] pwm_period_code;
   logic [4:0] min_off_time_code;
   logic [7:0] pulse_width_code;
   logic [15:0] cal_cnt;
   logic [15:0] cal_run;
   // PWM state
   logic [16:0] step_acc;
   logic [7:0] step_cnt;
   logic [7:0] period_lat;
   logic [7:0] on_lat;
   logic [4:0] off_lat;
   logic [7:0] low_steps;
   logic [7:0] high_steps;

   // Bus decode
   wire setup_phase = psel & ~penable;
   wire access_done = psel & penable & pready;
   wire wr_done = access_done & pwrite;
   wire aligned = (paddr[1:0] == 2'b00);
   wire upper_zero = (paddr >> 10) == '0;
   wire [7:0] reg_idx = paddr[9:2];
   wire hit_x3 = reg_idx == dcdc_ctrl_pkg::IDX_XTOR3;
   wire hit_x4 = reg_idx == dcdc_ctrl_pkg::IDX_XTOR4;
   wire hit_x5 = reg_idx == dcdc_ctrl_pkg::IDX_XTOR5;
   wire hit_x6 = reg_idx == dcdc_ctrl_pkg::IDX_XTOR6;
   wire hit_per = reg_idx == dcdc_ctrl_pkg::IDX_PERIOD;
   wire hit_dly = reg_idx == dcdc_ctrl_pkg::IDX_SWDELAY;
   wire hit_pw = reg_idx == dcdc_ctrl_pkg::IDX_PULSE;
   wire any_hit = hit_x3 | hit_x4 | hit_x5 | hit_x6 | hit_per | hit_dly
      | hit_pw;
   wire mapped = aligned & upper_zero & any_hit;

   wire [7:0] dly_read = {peak_monitor_cal, 1'b0, FF_SAME_POLARITY,
      min_off_time_code};
   wire [7:0] read_byte =
      !mapped ? 8'h00 :
      hit_x3 ? xtor3_current_code :
      hit_x4 ? xtor4_current_code :
      hit_x5 ? xtor5_current_code :
      hit_x6 ? xtor6_current_code :
      hit_per ? pwm_period_code :
      hit_dly ? dly_read :
      pulse_width_code;

   wire wr_per = wr_done & mapped & hit_per;
   wire wr_dly = wr_done & mapped & hit_dly;
   wire wr_pw = wr_done & mapped & hit_pw;
   wire cal_start = wr_dly & pwdata[dcdc_ctrl_pkg::CAL_BIT]
      & ~peak_monitor_cal;
   wire cal_last = peak_monitor_cal
      & (cal_cnt == 16'(CAL_CYCLES - 1));
   wire [7:0] next_period = {pwdata[7], 1'b1, pwdata[5:0]};

   // APB answer: no wait state, answer registered at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~mapped;
         if (setup_phase) begin
            prdata <= {24'h00_0000, read_byte}; // RULE_01 RULE_02 RULE_03 RULE_04
         end
      end
   end

   // Sense registers follow the monitor only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtor3_current_code <= 8'h00;
         xtor4_current_code <= 8'h00;
         xtor5_current_code <= 8'h00;
         xtor6_current_code <= 8'h00;
      end else begin
         xtor3_current_code <= ext_transistor_three; // RULE_01 RULE_11
         xtor4_current_code <= ext_transistor_four; // RULE_02 RULE_11
         xtor5_current_code <= ext_transistor_five; // RULE_03 RULE_11
         xtor6_current_code <= ext_transistor_six; // RULE_04 RULE_11
      end
   end

   // Writable control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_period_code <= dcdc_ctrl_pkg::PERIOD_RESET;
         min_off_time_code <= dcdc_ctrl_pkg::OFF_RESET;
         pulse_width_code <= dcdc_ctrl_pkg::PULSE_RESET;
      end else begin
         if (wr_per) begin
            pwm_period_code <= next_period; // RULE_05 RULE_06
         end
         if (wr_dly) begin
            min_off_time_code <= pwdata[dcdc_ctrl_pkg::OFF_MSB:0]; // RULE_09
         end
         if (wr_pw) begin
            pulse_width_code <= pwdata[7:0]; // RULE_10
         end
      end
   end

   // Peak monitor calibration sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peak_monitor_cal <= 1'b0;
         cal_cnt <= 16'h0000;
      end else if (cal_start) begin
         peak_monitor_cal <= 1'b1; // RULE_07
         cal_cnt <= 16'h0000;
      end else if (cal_last) begin
         peak_monitor_cal <= 1'b0; // RULE_12
         cal_cnt <= 16'h0000;
      end else if (peak_monitor_cal) begin
         cal_cnt <= cal_cnt + 16'h0001;
      end
   end

   // Length of the present calibration run, for checking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_run <= 16'h0000;
      end else if (peak_monitor_cal) begin
         cal_run <= cal_run + 16'h0001;
      end else begin
         cal_run <= 16'h0000;
      end
   end

   // Step tick: 61.035 ns steps from the 40 ns clock by phase accumulation
   wire [16:0] acc_sum = step_acc + 17'(dcdc_ctrl_pkg::CLK_PS);
   wire step_tick = acc_sum >= 17'(dcdc_ctrl_pkg::STEP_PS);
   wire [16:0] next_acc = step_tick ?
      acc_sum - 17'(dcdc_ctrl_pkg::STEP_PS) : acc_sum;

   // Period wrap and on-time for the next cycle
   wire wrap = step_cnt >= period_lat - 8'h01;
   wire [7:0] next_cnt = wrap ? 8'h00 : step_cnt + 8'h01;
   wire [7:0] pw_lim = (pulse_width_code < pwm_period_code) ?
      pulse_width_code : pwm_period_code;
   wire [7:0] off_total = {3'b000, min_off_time_code}
      + {2'b00, dcdc_ctrl_pkg::OFF_BASE_STEPS};
   wire [7:0] next_on = (pw_lim > off_total) ? pw_lim - off_total : 8'h00;
   wire next_drive = ~peak_monitor_cal &
      (step_tick ? ((wrap ? next_on : on_lat) > next_cnt)
                 : (on_lat > step_cnt));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_acc <= 17'h0_0000;
         step_cnt <= 8'h00;
         period_lat <= dcdc_ctrl_pkg::PERIOD_RESET;
         on_lat <= 8'h00;
         off_lat <= dcdc_ctrl_pkg::OFF_RESET;
      end else begin
         step_acc <= next_acc;
         if (step_tick) begin
            step_cnt <= next_cnt; // RULE_05
            if (wrap) begin
               period_lat <= pwm_period_code; // RULE_05
               on_lat <= next_on; // RULE_09 RULE_10
               off_lat <= min_off_time_code;
            end
         end
         // No partial pulse once calibration releases the drive
         if (peak_monitor_cal) begin
            on_lat <= 8'h00;
         end
      end
   end

   // Drive and feed-forward pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_drive_pin <= 1'b0;
         feedforward_pin <= ~FF_SAME_POLARITY;
      end else begin
         converter_drive_pin <= next_drive;
         feedforward_pin <= FF_SAME_POLARITY ? next_drive : ~next_drive; // RULE_08
      end
   end

   // Step counts of the present low and high runs, for checking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_steps <= 8'h00;
         high_steps <= 8'h00;
      end else begin
         if (converter_drive_pin) begin
            low_steps <= 8'h00;
         end else if (step_tick && low_steps != 8'hff) begin
            low_steps <= low_steps + 8'h01;
         end
         if (!converter_drive_pin) begin
            high_steps <= 8'h00;
         end else if (step_tick && high_steps != 8'hff) begin
            high_steps <= high_steps + 8'h01;
         end
      end
   end

   period_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
      pwm_period_code[dcdc_ctrl_pkg::PERIOD_FIXED_BIT] == 1'b1) // RULE_06
      else $error("period bit 6 not one");

   period_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_per |=> pwm_period_code == {$past(pwdata[7]), 1'b1,
         $past(pwdata[5:0])}) // RULE_05
      else $error("period write not stored");

   sense_low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      access_done && !pwrite && mapped && (hit_x3 || hit_x4)
      |-> prdata[31:8] == 24'h00_0000 && prdata[7:0] == (hit_x3 ?
         $past(ext_transistor_three, 2) : $past(ext_transistor_four, 2)))
      // RULE_01 RULE_02
      else $error("transistor 3/4 read wrong");

   sense_high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      access_done && !pwrite && mapped && (hit_x5 || hit_x6)
      |-> prdata[7:0] == (hit_x5 ? $past(ext_transistor_five, 2)
         : $past(ext_transistor_six, 2))) // RULE_03 RULE_04
      else $error("transistor 5/6 read wrong");

   sense_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && mapped && hit_x3 ##1 1'b1
      |-> xtor3_current_code == $past(ext_transistor_three)) // RULE_11
      else $error("sense register took a write");

   cal_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_dly && pwdata[7] && !peak_monitor_cal |=> peak_monitor_cal [*2]) // RULE_07
      else $error("calibration did not start");

   cal_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(peak_monitor_cal) |-> cal_run == 16'(CAL_CYCLES)) // RULE_12
      else $error("calibration did not end on time");

   cal_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      peak_monitor_cal |-> cal_cnt < 16'(CAL_CYCLES)) // RULE_12
      else $error("calibration overran");

   polarity_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      feedforward_pin == (FF_SAME_POLARITY ? converter_drive_pin
         : !converter_drive_pin)) // RULE_08
      else $error("feed-forward polarity wrong");

   polarity_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      access_done && !pwrite && mapped && hit_dly
      |-> prdata[dcdc_ctrl_pkg::POL_BIT] == FF_SAME_POLARITY
         && prdata[6] == 1'b0) // RULE_08
      else $error("polarity bit read wrong");

   min_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(converter_drive_pin) && !$past(peak_monitor_cal)
      |-> 9'(low_steps) + 9'h001 >= 9'($past(off_lat)) + 9'h004) // RULE_09
      else $error("off time below minimum");

   pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(converter_drive_pin) && !$past(peak_monitor_cal)
      |-> high_steps == on_lat) // RULE_10
      else $error("pulse width wrong");

   cal_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      peak_monitor_cal |=> !converter_drive_pin) // RULE_07
      else $error("drive active during calibration");

   off_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_dly |=> min_off_time_code == $past(pwdata[4:0])) // RULE_09
      else $error("off time write not stored");

   pulse_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_pw |=> pulse_width_code == $past(pwdata[7:0])) // RULE_10
      else $error("pulse code write not stored");

   cal_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      access_done && !pwrite && mapped && hit_dly
      |-> prdata[dcdc_ctrl_pkg::CAL_BIT]
         == $past(peak_monitor_cal)) // RULE_07
      else $error("calibration status read wrong");

   cal_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      peak_monitor_cal && !cal_last |=> peak_monitor_cal) // RULE_07
      else $error("calibration ended early");

   unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
      access_done && !mapped |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

endmodule : dcdc_ctrl

/* File: common/dcdc_ctrl_pkg.sv */
// Shared constants for the dc-dc converter timing and current sense block
package dcdc_ctrl_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_XTOR3 = 8'h56;
   localparam logic [7:0] IDX_XTOR4 = 8'h57;
   localparam logic [7:0] IDX_XTOR5 = 8'h58;
   localparam logic [7:0] IDX_XTOR6 = 8'h59;
   localparam logic [7:0] IDX_PERIOD = 8'h5c;
   localparam logic [7:0] IDX_SWDELAY = 8'h5d;
   localparam logic [7:0] IDX_PULSE = 8'h5e;

   // Field positions
   localparam int PERIOD_FIXED_BIT = 6;
   localparam int CAL_BIT = 7;
   localparam int POL_BIT = 5;
   localparam int OFF_MSB = 4;

   // Reset values
   localparam logic [7:0] PERIOD_RESET = 8'hff;
   localparam logic [4:0] OFF_RESET = 5'h00;
   localparam logic [7:0] PULSE_RESET = 8'h00;

   // Timing: converter step and clock period
   localparam int STEP_PS = 61035;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CLK_PS = CLK_PERIOD_NS * 1000;
   localparam logic [5:0] OFF_BASE_STEPS = 6'h04;
   localparam int CAL_CYCLES_DEFAULT = 1024;
endpackage : dcdc_ctrl_pkg

/* File: testbench/dcdc_pwm_timing_and_current_monitor_tb.sv */
// Self-checking bench for the converter timing and current sense block
`timescale 1ns/1ps
module dcdc_pwm_timing_and_current_monitor_tb;
   localparam int CAL_N = 6;
   localparam bit SAME = 1'b0;
   logic pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, drive, ffpin, cal, err;
   logic [7:0] xt [4];
   int num_errors, samples_checked, cal_cnt, h, l, ffbad, n;
   int m_per, m_off, m_pw, v, on_ps;
   int m_sense [4];

   dcdc_ctrl #(.CAL_CYCLES(CAL_N), .FF_SAME_POLARITY(SAME)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .ext_transistor_three(xt[0]), .ext_transistor_four(xt[1]),
      .ext_transistor_five(xt[2]), .ext_transistor_six(xt[3]),
      .converter_drive_pin(drive), .feedforward_pin(ffpin),
      .peak_monitor_cal(cal));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Calibration length in clocks
   always @(posedge pclk)
      if (cal === 1'b1) cal_cnt <= cal_cnt + 1;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   task automatic apb(input logic w, input logic [7:0] idx,
         input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         num_errors++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp,
         input logic exp_err);
      apb(1'b0, idx, 32'h0);
      check(rd, exp);
      check({31'h0, err}, {31'h0, exp_err});
   endtask : rchk

   task automatic step;
      @(posedge pclk);
      #1;
      n++;
      if (ffpin !== ~drive) ffbad++;
   endtask : step

   // One drive high run and the low run after it, in clocks
   task automatic measure;
      h = 0;
      l = 0;
      n = 0;
      while (drive !== 1'b0 && n < 1200) step();
      while (drive !== 1'b1 && n < 1200) step();
      while (drive === 1'b1 && n < 1200) begin
         step();
         h++;
      end
      while (drive === 1'b0 && n < 1200) begin
         step();
         l++;
      end
      if (n >= 1200) begin
         num_errors++;
         finish_test();
      end
   endtask : measure

   function automatic logic [31:0] near(input int a, input int b);
      return {31'h0, (a - b <= 80000) && (b - a <= 80000)};
   endfunction : near

   initial begin
      num_errors = 0;
      samples_checked = 0;
      cal_cnt = 0;
      ffbad = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      foreach (xt[i]) xt[i] = 8'h00;
      void'($urandom(88741));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      m_per = 'hff;
      m_off = 0;
      rchk(dcdc_ctrl_pkg::IDX_PERIOD, m_per, 1'b0);
      rchk(dcdc_ctrl_pkg::IDX_SWDELAY, 32'(SAME) << 5, 1'b0);
      rchk(dcdc_ctrl_pkg::IDX_PULSE, 32'h0, 1'b0);
      $display("reset values test done");
      // Zero, full scale, then random codes; writes must not land
      for (int k = 0; k < 4; k++) begin
         foreach (m_sense[i])
            m_sense[i] = k == 0 ? 0 : k == 1 ? 255 : $urandom_range(255);
         foreach (xt[i]) xt[i] <= 8'(m_sense[i]);
         @(posedge pclk);
         for (int i = 0; i < 4; i++) begin
            v = dcdc_ctrl_pkg::IDX_XTOR3 + i;
            apb(1'b1, 8'(v), $urandom);
            rchk(8'(v), m_sense[i], 1'b0);
         end
      end
      $display("sense register test done");
      for (int k = 0; k < 6; k++) begin
         v = k == 0 ? 0 : $urandom;
         apb(1'b1, dcdc_ctrl_pkg::IDX_PERIOD, v);
         m_per = (v & 'hbf) | 'h40;
         rchk(dcdc_ctrl_pkg::IDX_PERIOD, m_per, 1'b0);
      end
      rchk(8'h5f, 32'h0, 1'b1);
      $display("period and unmapped test done");
      m_off = 'h1f;
      cal_cnt = 0;
      apb(1'b1, dcdc_ctrl_pkg::IDX_SWDELAY, 32'hdf);
      @(posedge pclk);
      rchk(dcdc_ctrl_pkg::IDX_SWDELAY, 'h80 | (32'(SAME) << 5) | m_off, 1'b0);
      n = 0;
      while (cal !== 1'b0 && n < 100) step();
      if (n >= 100) begin
         num_errors++;
         finish_test();
      end
      check(cal_cnt, CAL_N);
      rchk(dcdc_ctrl_pkg::IDX_SWDELAY, (32'(SAME) << 5) | m_off, 1'b0);
      $display("calibration test done");
      // Short band plain case, then long band with pulse code past period
      for (int c = 0; c < 2; c++) begin
         m_per = c ? 'hc5 : 'h40;
         m_off = c ? 31 : 3;
         m_pw = c ? 'hff : 'h30;
         apb(1'b1, dcdc_ctrl_pkg::IDX_PERIOD, m_per);
         apb(1'b1, dcdc_ctrl_pkg::IDX_SWDELAY, m_off);
         apb(1'b1, dcdc_ctrl_pkg::IDX_PULSE, m_pw);
         rchk(dcdc_ctrl_pkg::IDX_PULSE, m_pw, 1'b0);
         repeat (3) measure();
         on_ps = ((m_pw < m_per ? m_pw : m_per) - m_off - 4) * 61035;
         check(near(h * 40000, on_ps), 32'h1);
         check({31'h0, l * 40000 + 80000 >= (m_off + 4) * 61035}, 32'h1);
         check(near((h + l) * 40000, m_per * 61035), 32'h1);
      end
      check(ffbad, 0);
      $display("pwm timing test done");
      // Second reset in mid-run must restore the reset values
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk(dcdc_ctrl_pkg::IDX_PERIOD, 32'(dcdc_ctrl_pkg::PERIOD_RESET),
         1'b0);
      rchk(dcdc_ctrl_pkg::IDX_SWDELAY, {26'h0, SAME, 5'h00}, 1'b0);
      rchk(dcdc_ctrl_pkg::IDX_PULSE, 32'(dcdc_ctrl_pkg::PULSE_RESET),
         1'b0);
      $display("mid-run reset test done");
      finish_test();
   end
endmodule : dcdc_pwm_timing_and_current_monitor_tb
